// ---- shf_framer.sv ----
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R1: every frame on the line opens and closes with a 0x7E flag.
// R2: the sender appends a two-byte CRC16 and the receiver checks it.
// R3: one user frame goes into exactly one line frame, never split or merged.
// R4: the information field is always a whole number of bytes.
// R5: bytes go onto the line most significant bit first and are rebuilt the same way.
// R6: at most 1500 information bytes plus 5 overhead bytes; longer frames are cut to 1500 bytes when sent and are rejected when received.
// R7: a zero is inserted after five ones in address, information and check fields, never in flags.
// R8: the address byte is always channel 01.
// R9: with nothing to send the transmitter keeps sending empty frames.
// R10: the receiver finds byte alignment from flags with no prior knowledge.
// R11: received frames failing the check are discarded and only good ones are delivered.
// R12: the receiver removes stuffed zeros, delimits on 0x7E and drops frames that are too short.
// R13: the check is CCITT x^16+x^12+x^5+1, preset all ones, over address and information.
module shf_framer
    import shf_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      reset,
    input  wire logic      link_clk,
    input  wire logic      rx_line,
    output logic           tx_line,
    input  wire shf_byte_t tx_in,
    input  wire logic      tx_valid,
    output logic           tx_ready,
    output shf_byte_t      rx_out,
    output logic           rx_valid,
    output logic           rx_frame_bad
);

    // ------------------------------------------------------------------
    // link clock and data sampling
    // ------------------------------------------------------------------
    logic lclk_s1_reg, lclk_s2_reg, lclk_s3_reg;
    logic rxd_s1_reg, rxd_s2_reg;

    always_ff @(posedge clk) begin
        lclk_s1_reg <= link_clk;
        lclk_s2_reg <= lclk_s1_reg;
        lclk_s3_reg <= lclk_s2_reg;
        rxd_s1_reg  <= rx_line;
        rxd_s2_reg  <= rxd_s1_reg;
    end

    // transmit on falling edge so the modem samples a settled bit on rising
    wire tx_tick = lclk_s3_reg & ~lclk_s2_reg;
    wire rx_tick = lclk_s2_reg & ~lclk_s3_reg;

    // ------------------------------------------------------------------
    // transmit serialiser
    // ------------------------------------------------------------------
    shf_tx_state_t tx_state_reg, tx_state_next;
    logic [7:0]    tx_shreg_reg, tx_load_byte;
    logic [2:0]    tx_bitcnt_reg, tx_ones_reg;
    logic          tx_stuff_reg, tx_cur_last_reg;
    logic [15:0]   tx_crc_reg;
    logic [10:0]   tx_info_cnt_reg;
    shf_byte_t     hold_reg;
    logic          hold_full_reg, drop_reg, tx_ready_reg, tx_line_reg;

    wire tx_bit      = tx_shreg_reg[7];
    wire tx_send     = tx_tick & ~tx_stuff_reg;
    wire tx_byte_end = tx_send & (tx_bitcnt_reg == 3'h7);
    wire tx_stuffed  = (tx_state_reg != TX_OPEN) & (tx_state_reg != TX_CLOSE);
    wire tx_crc_on   = (tx_state_reg == TX_ADDR) | (tx_state_reg == TX_INFO);
    wire [15:0] tx_crc_after = tx_crc_on ? shf_crc_bit(tx_crc_reg, tx_bit) : tx_crc_reg; // R13
    wire [2:0]  tx_ones_next = (tx_stuffed & tx_bit) ? tx_ones_reg + 3'h1 : 3'h0;
    wire        tx_stuff_next = tx_stuffed & tx_bit & (tx_ones_reg == SHF_STUFF_RUN - 3'h1); // R7
    wire info_go     = hold_full_reg & ~tx_cur_last_reg & (tx_info_cnt_reg < SHF_MAX_INFO); // R6
    wire consume     = tx_byte_end & (((tx_state_reg == TX_ADDR) & hold_full_reg)
                                    | ((tx_state_reg == TX_INFO) & info_go));
    // closing before the user's last byte: drop the rest rather than split it
    wire close_early = tx_byte_end & (tx_state_reg == TX_INFO) & ~info_go & ~tx_cur_last_reg; // R3
    wire drop_set    = ~(hold_full_reg & hold_reg.last);
    wire take        = tx_ready_reg & tx_valid;
    wire hold_full_next = (close_early | consume) ? 1'b0 : ((take & ~drop_reg) | hold_full_reg);
    wire drop_next   = close_early ? drop_set : (drop_reg & ~(take & tx_in.last));
    wire tx_ready_next = drop_next | ~hold_full_next;

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_load_byte  = SHF_FLAG;
        case (tx_state_reg)
            TX_OPEN: begin
                tx_state_next = TX_ADDR;
                tx_load_byte  = SHF_CHAN_ADDR; // R8
            end
            TX_ADDR, TX_INFO: begin
                if ((tx_state_reg == TX_ADDR) ? hold_full_reg : info_go) begin
                    tx_state_next = TX_INFO;
                    tx_load_byte  = hold_reg.data;
                end else begin
                    // no data waiting at the address: empty frame
                    tx_state_next = TX_FCS_HI; // R9
                    tx_load_byte  = tx_crc_after[15:8]; // R2
                end
            end
            TX_FCS_HI: begin
                tx_state_next = TX_FCS_LO;
                tx_load_byte  = tx_crc_reg[7:0];
            end
            TX_FCS_LO: begin
                tx_state_next = TX_CLOSE; // R1
                tx_load_byte  = SHF_FLAG;
            end
            TX_CLOSE: begin
                tx_state_next = TX_OPEN; // R1
                tx_load_byte  = SHF_FLAG;
            end
            default: begin
                tx_state_next = TX_OPEN;
                tx_load_byte  = SHF_FLAG;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_state_reg    <= TX_OPEN;
            tx_shreg_reg    <= SHF_FLAG;
            tx_bitcnt_reg   <= 3'h0;
            tx_ones_reg     <= 3'h0;
            tx_stuff_reg    <= 1'b0;
            tx_crc_reg      <= SHF_CRC_INIT;
            tx_line_reg     <= 1'b0;
        end else if (tx_stuff_reg & tx_tick) begin
            tx_line_reg     <= 1'b0; // R7
            tx_stuff_reg    <= 1'b0;
            tx_ones_reg     <= 3'h0;
        end else if (tx_send) begin
            tx_line_reg     <= tx_bit; // R5
            tx_shreg_reg    <= tx_byte_end ? tx_load_byte : {tx_shreg_reg[6:0], 1'b0};
            tx_bitcnt_reg   <= tx_bitcnt_reg + 3'h1;
            tx_ones_reg     <= tx_ones_next;
            tx_stuff_reg    <= tx_stuff_next;
            tx_crc_reg      <= (tx_byte_end & (tx_state_reg == TX_OPEN)) ? SHF_CRC_INIT
                                                                          : tx_crc_after;
            if (tx_byte_end) begin
                tx_state_reg <= tx_state_next;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hold_reg        <= '0;
            hold_full_reg   <= 1'b0;
            drop_reg        <= 1'b0;
            tx_ready_reg    <= 1'b0;
            tx_cur_last_reg <= 1'b0;
            tx_info_cnt_reg <= 11'h000;
        end else begin
            hold_full_reg   <= hold_full_next;
            drop_reg        <= drop_next;
            tx_ready_reg    <= tx_ready_next;
            if (take & ~drop_reg) begin
                hold_reg    <= tx_in;
            end
            if (consume) begin
                tx_cur_last_reg <= hold_reg.last;
                tx_info_cnt_reg <= (tx_state_reg == TX_ADDR) ? 11'h001
                                                             : tx_info_cnt_reg + 11'h001;
            end else if (tx_byte_end & (tx_state_reg == TX_ADDR)) begin
                tx_cur_last_reg <= 1'b0;
                tx_info_cnt_reg <= 11'h000;
            end
        end
    end

    assign tx_line  = tx_line_reg;
    assign tx_ready = tx_ready_reg;

    // ------------------------------------------------------------------
    // receive deframer
    // ------------------------------------------------------------------
    logic [7:0]  win_reg, rx_shreg_reg;
    logic [3:0]  win_fill_reg;
    logic        in_frame_reg, addr_ok_reg;
    logic [2:0]  rx_ones_reg, rx_bitcnt_reg;
    logic [15:0] rx_crc_reg;
    logic [10:0] rx_nbytes_reg;

    // bits leave an 8-bit window before processing so a flag is never destuffed
    wire [7:0]  win_next    = {win_reg[6:0], rxd_s2_reg};
    wire        rx_flag     = rx_tick & (win_next == SHF_FLAG); // R10
    wire        rx_b        = win_reg[7];
    wire        rx_proc     = rx_tick & (win_fill_reg == SHF_WIN_FULL) & in_frame_reg;
    wire        rx_run5     = rx_ones_reg == SHF_STUFF_RUN;
    wire        rx_abort    = rx_proc & rx_run5 & rx_b;
    wire        rx_data_bit = rx_proc & ~rx_run5; // R12
    wire        rx_byte_done = rx_data_bit & (rx_bitcnt_reg == 3'h7);
    wire [7:0]  rx_byte     = {rx_shreg_reg[6:0], rx_b};
    wire [15:0] rx_crc_after = rx_data_bit ? shf_crc_bit(rx_crc_reg, rx_b) : rx_crc_reg;
    wire [2:0]  rx_bitcnt_after = rx_data_bit ? rx_bitcnt_reg + 3'h1 : rx_bitcnt_reg;
    wire        rx_nb_sat   = rx_nbytes_reg == 11'h7FF;
    wire [10:0] rx_nbytes_after = rx_nbytes_reg + {10'h000, rx_byte_done & ~rx_nb_sat};
    wire        frame_end   = rx_flag & in_frame_reg & ~rx_abort & (rx_nbytes_after != 11'h000);
    wire        frame_ok    = (rx_bitcnt_after == 3'h0) // R4
                            & (rx_nbytes_after >= SHF_RX_MIN_BYTES) // R12
                            & (rx_nbytes_after <= SHF_RX_MAX_BYTES) // R6
                            & (rx_crc_after == 16'h0000) & addr_ok_reg; // R2
    wire        rd_start    = frame_end & frame_ok & (rx_nbytes_after != SHF_RX_MIN_BYTES); // R11
    wire        mem_we      = rx_byte_done & (rx_nbytes_reg != 11'h000)
                            & (rx_nbytes_reg <= SHF_RX_MAX_BYTES - 11'h001);
    wire [10:0] mem_waddr   = rx_nbytes_reg - 11'h001;

    always_ff @(posedge clk) begin
        if (reset) begin
            win_reg       <= 8'h00;
            win_fill_reg  <= 4'h0;
            in_frame_reg  <= 1'b0;
            addr_ok_reg   <= 1'b0;
            rx_ones_reg   <= 3'h0;
            rx_bitcnt_reg <= 3'h0;
            rx_shreg_reg  <= 8'h00;
            rx_crc_reg    <= SHF_CRC_INIT;
            rx_nbytes_reg <= 11'h000;
        end else if (rx_flag) begin
            win_reg       <= win_next;
            win_fill_reg  <= 4'h0;
            in_frame_reg  <= 1'b1; // R10
            rx_ones_reg   <= 3'h0;
            rx_bitcnt_reg <= 3'h0;
            rx_crc_reg    <= SHF_CRC_INIT; // R13
            rx_nbytes_reg <= 11'h000;
        end else if (rx_tick) begin
            win_reg       <= win_next;
            win_fill_reg  <= (win_fill_reg == SHF_WIN_FULL) ? SHF_WIN_FULL : win_fill_reg + 4'h1;
            in_frame_reg  <= in_frame_reg & ~rx_abort;
            rx_ones_reg   <= (rx_proc & rx_b & ~rx_run5) ? rx_ones_reg + 3'h1 : 3'h0;
            rx_bitcnt_reg <= rx_bitcnt_after;
            rx_crc_reg    <= rx_crc_after;
            rx_nbytes_reg <= rx_nbytes_after;
            if (rx_data_bit) begin
                rx_shreg_reg <= rx_byte; // R5
            end
            if (rx_byte_done & (rx_nbytes_reg == 11'h000)) begin
                addr_ok_reg <= rx_byte == SHF_CHAN_ADDR; // R8
            end
        end
    end

    // ------------------------------------------------------------------
    // delivery of checked frames
    // ------------------------------------------------------------------
    // reading runs a byte a clock, far ahead of the next frame's writes
    logic [10:0] rd_ptr_reg, rd_len_reg;
    logic        rd_active_reg, rx_valid_reg, rx_last_reg, rx_bad_reg;
    logic [7:0]  mem_q;

    wire rd_last = rd_ptr_reg == rd_len_reg - 11'h001;

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_ptr_reg    <= 11'h000;
            rd_len_reg    <= 11'h000;
            rd_active_reg <= 1'b0;
            rx_valid_reg  <= 1'b0;
            rx_last_reg   <= 1'b0;
            rx_bad_reg    <= 1'b0;
        end else begin
            rx_valid_reg  <= rd_active_reg;
            rx_last_reg   <= rd_active_reg & rd_last;
            rx_bad_reg    <= frame_end & ~frame_ok; // R11
            if (rd_start) begin
                rd_ptr_reg    <= 11'h000;
                rd_len_reg    <= rx_nbytes_after - SHF_RX_MIN_BYTES;
                rd_active_reg <= 1'b1;
            end else if (rd_active_reg) begin
                rd_ptr_reg    <= rd_ptr_reg + 11'h001;
                rd_active_reg <= ~rd_last;
            end
        end
    end

    shf_frame_mem u_mem (
        .clk     (clk),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (rx_byte),
        .rd_addr (rd_ptr_reg),
        .rd_data (mem_q)
    );

    assign rx_out       = '{last: rx_last_reg, data: mem_q};
    assign rx_valid     = rx_valid_reg;
    assign rx_frame_bad = rx_bad_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_flag_byte;
        @(posedge clk) disable iff (reset)
        ((tx_state_reg == TX_OPEN) | (tx_state_reg == TX_CLOSE)) & (tx_bitcnt_reg == 3'h0)
        |-> tx_shreg_reg == SHF_FLAG;
    endproperty
    a_flag_byte: assert property (p_flag_byte) else $error("flag byte not 7E"); // R1

    property p_addr_byte;
        @(posedge clk) disable iff (reset)
        (tx_state_reg == TX_ADDR) & (tx_bitcnt_reg == 3'h0) |-> tx_shreg_reg == SHF_CHAN_ADDR;
    endproperty
    a_addr_byte: assert property (p_addr_byte) else $error("address byte not 01"); // R8

    property p_fcs_load;
        @(posedge clk) disable iff (reset)
        $rose(tx_state_reg == TX_FCS_HI) |-> tx_shreg_reg == tx_crc_reg[15:8];
    endproperty
    a_fcs_load: assert property (p_fcs_load) else $error("check sequence high byte wrong"); // R2

    property p_stuff_zero;
        @(posedge clk) disable iff (reset)
        tx_tick & tx_stuff_reg |=> ~tx_line & (tx_ones_reg == 3'h0);
    endproperty
    a_stuff_zero: assert property (p_stuff_zero) else $error("stuffed bit not zero"); // R7

    property p_no_flag_stuff;
        @(posedge clk) disable iff (reset)
        (tx_state_reg == TX_OPEN) & tx_send |=> ~tx_stuff_reg;
    endproperty
    a_no_flag_stuff: assert property (p_no_flag_stuff) else $error("stuffing in flag"); // R7

    property p_msb_first;
        @(posedge clk) disable iff (reset)
        tx_send |=> tx_line == $past(tx_shreg_reg[7]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("bit order wrong"); // R5

    property p_info_max;
        @(posedge clk) disable iff (reset)
        tx_info_cnt_reg <= SHF_MAX_INFO;
    endproperty
    a_info_max: assert property (p_info_max) else $error("information field too long"); // R6

    property p_empty_frame;
        @(posedge clk) disable iff (reset)
        tx_byte_end & (tx_state_reg == TX_ADDR) & ~hold_full_reg |=> tx_state_reg == TX_FCS_HI;
    endproperty
    a_empty_frame: assert property (p_empty_frame) else $error("no empty frame when idle"); // R9

    property p_bad_not_sent;
        @(posedge clk) disable iff (reset)
        frame_end & (rx_crc_after != 16'h0000) |-> ~rd_start ##1 rx_frame_bad;
    endproperty
    a_bad_not_sent: assert property (p_bad_not_sent) else $error("bad frame delivered"); // R11

    property p_destuff;
        @(posedge clk) disable iff (reset)
        rx_proc & rx_run5 & ~rx_b & ~rx_flag |=> $stable(rx_bitcnt_reg) & (rx_ones_reg == 3'h0);
    endproperty
    a_destuff: assert property (p_destuff) else $error("stuffed zero kept"); // R12

endmodule

`default_nettype wire

// ---- shf_pkg.sv ----
package shf_pkg;

    // ------------------------------------------------------------------
    // framing constants
    // ------------------------------------------------------------------
    localparam logic [7:0]  SHF_FLAG         = 8'h7E;
    localparam logic [7:0]  SHF_CHAN_ADDR    = 8'h01;
    localparam logic [15:0] SHF_CRC_POLY     = 16'h1021;
    localparam logic [15:0] SHF_CRC_INIT     = 16'hFFFF;
    localparam logic [10:0] SHF_MAX_INFO     = 11'h05DC;
    localparam logic [10:0] SHF_OVERHEAD     = 11'h0005;
    // address + info + check sequence, flags not counted
    localparam logic [10:0] SHF_RX_MAX_BYTES = SHF_MAX_INFO + SHF_OVERHEAD - 11'h0002;
    localparam logic [10:0] SHF_RX_MIN_BYTES = 11'h0003;
    localparam logic [2:0]  SHF_STUFF_RUN    = 3'h5;
    localparam logic [3:0]  SHF_WIN_FULL     = 4'h8;

    // ------------------------------------------------------------------
    // frame memory
    // ------------------------------------------------------------------
    localparam int          SHF_MEM_AW       = 11;
    localparam int          SHF_MEM_DEPTH    = 2048;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } shf_byte_t;

    typedef enum logic [2:0] {
        TX_OPEN   = 3'b000,
        TX_ADDR   = 3'b001,
        TX_INFO   = 3'b010,
        TX_FCS_HI = 3'b011,
        TX_FCS_LO = 3'b100,
        TX_CLOSE  = 3'b101
    } shf_tx_state_t;

    function automatic logic [15:0] shf_crc_bit(input logic [15:0] crc, input logic b);
        logic fb;
        fb = crc[15] ^ b;
        shf_crc_bit = {crc[14:0], 1'b0} ^ (fb ? SHF_CRC_POLY : 16'h0000);
    endfunction

endpackage

// ---- shf_frame_mem.sv ----
`timescale 1ns/100ps
`default_nettype none

module shf_frame_mem
    import shf_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  wr_en,
    input  wire logic [SHF_MEM_AW-1:0] wr_addr,
    input  wire logic [7:0]            wr_data,
    input  wire logic [SHF_MEM_AW-1:0] rd_addr,
    output logic      [7:0]            rd_data
);

    logic [7:0] mem [SHF_MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

`default_nettype wire

// ---- shf_link_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module shf_link_model (
    output logic      link_clk,
    output logic      rx_line,
    input  wire logic tx_line,
    input  wire logic loop_en
);
    bit         q_inj[$];
    bit         cur[$];
    bit         last_frm[$];
    int         n_frm = 0;
    logic       txb   = 1'b0;
    logic [2:0] fi    = 3'h0;
    logic [7:0] win   = 8'h00;

    // ------------------------------------------------------------
    // clock and line
    // ------------------------------------------------------------
    // continuous link: the modem clock never stops
    initial begin
        link_clk = 1'b0;
        rx_line  = 1'b0;
        #137;
        forever #400 link_clk = ~link_clk;
    end

    // split the sent stream at each flag, flags removed
    always @(posedge link_clk) begin
        txb = tx_line;
        win = {win[6:0], tx_line};
        cur.push_back(tx_line);
        if (win == 8'h7E) begin
            if (cur.size() > 8) begin
                last_frm = cur[0:cur.size()-9];
                n_frm++;
            end
            cur = {};
        end
    end

    // idle fill is flags, so the line never carries stale bits
    always @(negedge link_clk) begin
        if (loop_en)
            rx_line <= txb;
        // start injected bits on a flag boundary so no half flag precedes them
        else if (q_inj.size() > 0 && fi == 3'h0)
            rx_line <= q_inj.pop_front();
        else begin
            rx_line <= 8'h7E >> (3'h7 - fi);
            fi      <= fi + 3'h1;
        end
    end
endmodule

`default_nettype wire

// ---- tb_shf_framer.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_shf_framer
    import shf_pkg::*;
;
    typedef bit         shf_bq_t[$];
    typedef logic [7:0] shf_dq_t[$];

    logic      clk      = 1'b0;
    logic      reset    = 1'b1;
    logic      tx_valid = 1'b0;
    logic      loop_en  = 1'b1;
    shf_byte_t tx_in    = '0;
    logic      link_clk;
    logic      rx_line;
    logic      tx_line;
    logic      tx_ready;
    shf_byte_t rx_out;
    logic      rx_valid;
    logic      rx_frame_bad;
    shf_byte_t rx_q[$];
    int        n_rx_frm = 0;
    int        n_bad    = 0;
    int        n_errors = 0;
    int        samples_checked = 0;
    shf_bq_t   fl = '{0, 1, 1, 1, 1, 1, 1, 0};

    always #50 clk = ~clk;

    shf_framer i_shf_framer (
        .clk          (clk),
        .reset        (reset),
        .link_clk     (link_clk),
        .rx_line      (rx_line),
        .tx_line      (tx_line),
        .tx_in        (tx_in),
        .tx_valid     (tx_valid),
        .tx_ready     (tx_ready),
        .rx_out       (rx_out),
        .rx_valid     (rx_valid),
        .rx_frame_bad (rx_frame_bad)
    );

    shf_link_model i_shf_link_model (
        .link_clk (link_clk),
        .rx_line  (rx_line),
        .tx_line  (tx_line),
        .loop_en  (loop_en)
    );

    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            rx_q.push_back(rx_out);
            if (rx_out.last === 1'b1)
                n_rx_frm++;
        end
        if (rx_frame_bad === 1'b1)
            n_bad++;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] crc16(shf_dq_t d);
        logic [15:0] c = 16'hFFFF;
        foreach (d[i])
            for (int k = 7; k >= 0; k--)
                c = (c << 1) ^ ((c[15] ^ d[i][k]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction

    // mode 0 good check, 1 corrupted check, 2 no check bytes
    function automatic shf_bq_t body(shf_dq_t d, int mode);
        shf_bq_t     q;
        logic [15:0] c;
        int          ones = 0;
        c = crc16(d) ^ {15'h0000, mode == 1};
        if (mode != 2) begin
            d.push_back(c[15:8]);
            d.push_back(c[7:0]);
        end
        foreach (d[i])
            for (int k = 7; k >= 0; k--) begin
                q.push_back(d[i][k]);
                ones = d[i][k] ? ones + 1 : 0;
                if (ones == 5) begin
                    q.push_back(1'b0);
                    ones = 0;
                end
            end
        return q;
    endfunction

    task automatic cmp_bits(shf_bq_t e);
        check("tx frame bits", i_shf_link_model.last_frm.size(), e.size());
        foreach (e[i])
            if (i < i_shf_link_model.last_frm.size())
                check("tx bit", i_shf_link_model.last_frm[i], e[i]);
    endtask

    task automatic send(shf_dq_t d);
        foreach (d[i]) begin
            tx_in    <= '{last: (i == d.size() - 1), data: d[i]};
            tx_valid <= 1'b1;
            @(posedge clk);
            while (tx_ready !== 1'b1)
                @(posedge clk);
        end
        tx_valid <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_idle();
        repeat (2) @(i_shf_link_model.n_frm);
        cmp_bits(body('{8'h01}, 0));
        check("rx frames", n_rx_frm, 0);
        check("bad frames", n_bad, 0);
        $display("test idle done");
    endtask

    task automatic t_loop();
        shf_dq_t   a = '{8'hFF, 8'hFF, 8'h7E, 8'h3C};
        shf_byte_t e[$];
        send(a);
        repeat (6) begin
            @(i_shf_link_model.n_frm);
            if (i_shf_link_model.last_frm.size() != body('{8'h01}, 0).size())
                break;
        end
        cmp_bits(body({8'h01, a}, 0));
        send('{8'h7D});
        for (int i = 0; i < 4000 && n_rx_frm < 2; i++)
            @(posedge clk);
        foreach (a[i])
            e.push_back('{last: (i == 3), data: a[i]});
        e.push_back('{last: 1'b1, data: 8'h7D});
        check("rx bytes", rx_q.size(), 5);
        foreach (e[i])
            if (i < rx_q.size())
                check("rx byte", rx_q[i], e[i]);
        check("bad frames", n_bad, 0);
        $display("test loop done");
    endtask

    task automatic t_inject();
        int r0;
        int b0;
        loop_en <= 1'b0;
        repeat (400) @(posedge clk);
        r0 = rx_q.size();
        b0 = n_bad;
        // odd prefix so alignment must come from the flag alone
        i_shf_link_model.q_inj = {1'b1, 1'b0, 1'b1, fl, body('{8'h01, 8'hFE, 8'h3F}, 0),
            fl, fl, body('{8'h01, 8'hAA}, 1), fl, fl, body('{8'h01, 8'h12}, 2),
            fl, fl, body('{8'h02, 8'h33}, 0), fl};
        while (i_shf_link_model.q_inj.size() > 0)
            @(posedge clk);
        repeat (40) @(posedge clk);
        check("rx bytes", rx_q.size() - r0, 2);
        if (rx_q.size() >= r0 + 2) begin
            check("rx byte", rx_q[r0], {1'b0, 8'hFE});
            check("rx byte", rx_q[r0+1], {1'b1, 8'h3F});
        end
        check("bad frames", n_bad - b0, 3);
        $display("test inject done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_idle();
        t_loop();
        t_inject();
        test_done();
    end
endmodule

`default_nettype wire
